// ---- ira_params.svh ----
// Constants of the interrupt request arbiter: offsets, fields, reset values, vectors.
`ifndef IRA_PARAMS_SVH
`define IRA_PARAMS_SVH
`define IRA_NSRC 19
`define IRA_CTL_BASE 8'h00
`define IRA_STAT_OFS 8'h80
`define IRA_F_REQ 0
`define IRA_F_MASK 1
`define IRA_F_MAC 2
`define IRA_F_PRL 3
`define IRA_F_CSE 5
`define IRA_CTL_RST 6'h1a
`define IRA_VEC_NMI 16'h0004
`define IRA_VEC_MASK0 16'h0006
`define IRA_MSW_MASK0 16'hfe06
`define IRA_VEC_OPR 16'h003c
`define IRA_VEC_SOFT 16'h003e
`define IRA_VEC_NONE 16'h0000
`define IRA_NO_LEVEL 3'h4
`endif

// ---- ira_pkg.sv ----
// Types shared by the interrupt request arbiter.
package ira_pkg;
    // Class of the request offered to the core.
    typedef enum logic [3:0] {
        KIND_NMI = 4'h1,
        KIND_OPR = 4'h2,
        KIND_SOFT = 4'h4,
        KIND_MASK = 4'h8
    } ira_kind_t;
    // Service mode of the request offered to the core.
    typedef enum logic [2:0] {
        MODE_VEC = 3'h1,
        MODE_CTX = 3'h2,
        MODE_MAC = 3'h4
    } ira_mode_t;
endpackage

// ---- ira_arbiter.sv ----
// Interrupt request arbiter with AXI4-Lite control registers.
`timescale 1ns/10ps
`default_nettype none
`include "ira_params.svh"
module ira_arbiter #(
    parameter int NSRC = `IRA_NSRC, // Number of maskable sources.
    parameter int AW = 8, // Register address width.
    parameter logic [`IRA_NSRC-1:0] MACRO_OK = '1 // Sources able to use macro service.
) (
    input wire logic clk_sys_i, // System clock.
    input wire logic srst_i, // Synchronous reset, active high.
    input wire logic [AW-1:0] s_axi_awaddr, // Write address.
    input wire logic s_axi_awvalid, // Write address valid.
    output logic s_axi_awready, // Write address ready.
    input wire logic [31:0] s_axi_wdata, // Write data.
    input wire logic [3:0] s_axi_wstrb, // Write strobes.
    input wire logic s_axi_wvalid, // Write data valid.
    output logic s_axi_wready, // Write data ready.
    output logic [1:0] s_axi_bresp, // Write response.
    output logic s_axi_bvalid, // Write response valid.
    input wire logic s_axi_bready, // Write response ready.
    input wire logic [AW-1:0] s_axi_araddr, // Read address.
    input wire logic s_axi_arvalid, // Read address valid.
    output logic s_axi_arready, // Read address ready.
    output logic [31:0] s_axi_rdata, // Read data.
    output logic [1:0] s_axi_rresp, // Read response.
    output logic s_axi_rvalid, // Read data valid.
    input wire logic s_axi_rready, // Read data ready.
    input wire logic [NSRC-1:0] src_req_i, // Peripheral request pulses, bit = rank.
    input wire logic global_irq_enable_i, // Enable bit of the program status word.
    input wire logic break_instruction_i, // Plain break executed, pulse.
    input wire logic break_context_instruction_i, // Context break executed, pulse.
    input wire logic opr_standby_bad_i, // Illegal operand to the standby control register.
    input wire logic opr_watchdog_bad_i, // Illegal operand to the watchdog mode register.
    input wire logic opr_memory_bad_i, // Illegal operand of the memory instruction.
    input wire logic wdt_overflow_i, // Watchdog overflow, pulse.
    input wire logic reti_i, // Return from a maskable handler, pulse.
    input wire logic nmi_reti_i, // Return from the non-maskable handler, pulse.
    output logic ack_valid_o, // Request offered to the core.
    input wire logic ack_ready_i, // Core accepts the offered request.
    output ira_pkg::ira_kind_t ack_kind_o, // Class of the offered request.
    output ira_pkg::ira_mode_t ack_mode_o, // Service mode of the offered request.
    output logic [15:0] ack_vector_o, // Vector table slot.
    output logic [15:0] ack_msw_o, // Macro service control word slot.
    output logic [4:0] ack_src_o, // Rank of the maskable source.
    output logic [1:0] ack_level_o // Programmed level of the maskable source.
);
    // The parameter check and macro mask width allow at most 19 sources.
    if (NSRC < 1 || NSRC > `IRA_NSRC || AW < 8) begin : g_bad
        $error("ira_arbiter: unsupported parameters");
    end

    logic [5:0] ctl [NSRC]; // Per-source control registers.
    logic [3:0] ispr; // In-service levels, bit 0 highest.
    logic nmi_pend; // Watchdog request waiting.
    logic nmi_busy; // Non-maskable handler running.
    logic opr_pend; // Operand error waiting.
    logic break_pend; // Plain break waiting.
    logic break_ctx_pend; // Context break waiting.
    logic take; // Core takes the offer this cycle.
    logic launch; // A new offer is loaded this cycle.
    logic cand_ok; // Some request is eligible.
    logic mac_ok; // A macro service request is eligible.
    logic best_ok; // A vectored maskable request is eligible.
    logic [4:0] mac_i; // Rank of the macro winner.
    logic [4:0] best_i; // Rank of the vectored winner.
    logic [2:0] best_l; // Level of the vectored winner.
    logic [2:0] cur_l; // Level currently in service.
    logic [3:0] low_bit; // Highest-priority in-service bit.
    logic wr_fire; // Write address and data taken.
    logic [5:0] wr_dec; // Decoded write address.
    logic [5:0] rd_dec; // Decoded read address.
    ira_pkg::ira_kind_t next_kind; // Class of the candidate.
    ira_pkg::ira_mode_t next_mode; // Mode of the candidate.
    logic [15:0] next_vec; // Vector of the candidate.
    logic [15:0] next_msw; // Control word slot of the candidate.
    logic [4:0] next_src; // Rank of the candidate.
    logic [1:0] next_lvl; // Level of the candidate.

    // Decodes a control register address into {hit, rank}.
    function automatic logic [5:0] dec_ctl(input logic [AW-1:0] a);
        logic hit;
        hit = (a[1:0] == 2'h0) && (int'(a[AW-1:2]) < NSRC);
        return {hit, a[6:2]};
    endfunction

    // Vector slot of a maskable source from its rank.
    function automatic logic [15:0] vec_of(input logic [4:0] r);
        return `IRA_VEC_MASK0 + {10'h000, r, 1'b0};
    endfunction

    // Macro service control word slot of a maskable source.
    function automatic logic [15:0] msw_of(input logic [4:0] r);
        return `IRA_MSW_MASK0 + {10'h000, r, 1'b0};
    endfunction

    // Level in service, or four when nothing runs.
    always_comb begin
        cur_l = `IRA_NO_LEVEL;
        for (int l = 3; l >= 0; l--) begin
            if (ispr[l]) begin
                cur_l = 3'(l);
            end
        end
    end
    assign low_bit = ispr & (~ispr + 4'h1);

    // Scans sources: macro first, then lowest level, then lowest rank.
    always_comb begin
        mac_ok = 1'b0;
        mac_i = 5'h00;
        best_ok = 1'b0;
        best_i = 5'h00;
        best_l = `IRA_NO_LEVEL;
        for (int i = 0; i < NSRC; i++) begin
            // Pending and not masked.
            if (ctl[i][`IRA_F_REQ] && !ctl[i][`IRA_F_MASK]) begin
                if (ctl[i][`IRA_F_MAC] && MACRO_OK[i]) begin
                    // Macro service skips level and enable.
                    if (!mac_ok) begin
                        mac_ok = 1'b1;
                        mac_i = 5'(i);
                    end
                end else if (global_irq_enable_i && {1'b0, ctl[i][4:3]} < cur_l
                             && {1'b0, ctl[i][4:3]} < best_l) begin
                    // Strict compare keeps the lower rank on a tie.
                    best_ok = 1'b1;
                    best_i = 5'(i);
                    best_l = {1'b0, ctl[i][4:3]};
                end
            end
        end
    end

    // Chooses the candidate: non-maskable, operand, software, maskable.
    always_comb begin
        cand_ok = 1'b1;
        next_kind = ira_pkg::KIND_MASK;
        next_mode = ira_pkg::MODE_VEC;
        next_vec = `IRA_VEC_NONE;
        next_msw = `IRA_VEC_NONE;
        next_src = 5'h00;
        next_lvl = 2'h0;
        if (nmi_pend && !nmi_busy) begin
            next_kind = ira_pkg::KIND_NMI;
            next_vec = `IRA_VEC_NMI;
        end else if (opr_pend) begin
            next_kind = ira_pkg::KIND_OPR;
            next_vec = `IRA_VEC_OPR;
        end else if (break_pend) begin
            next_kind = ira_pkg::KIND_SOFT;
            next_vec = `IRA_VEC_SOFT;
        end else if (break_ctx_pend) begin
            // Vector comes from the register bank.
            next_kind = ira_pkg::KIND_SOFT;
            next_mode = ira_pkg::MODE_CTX;
        end else if (mac_ok) begin
            next_mode = ira_pkg::MODE_MAC;
            next_src = mac_i;
            next_lvl = ctl[mac_i][4:3];
            next_vec = vec_of(mac_i);
            next_msw = msw_of(mac_i);
        end else if (best_ok) begin
            next_mode = ctl[best_i][`IRA_F_CSE] ? ira_pkg::MODE_CTX : ira_pkg::MODE_VEC;
            next_src = best_i;
            next_lvl = best_l[1:0];
            next_vec = vec_of(best_i);
            next_msw = msw_of(best_i);
        end else begin
            cand_ok = 1'b0;
        end
    end

    assign take = ack_valid_o && ack_ready_i;
    assign launch = !ack_valid_o && cand_ok;

    // Offer stage: holds the winner until the core takes it.
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            ack_valid_o <= 1'b0;
            ack_kind_o <= ira_pkg::KIND_MASK;
            ack_mode_o <= ira_pkg::MODE_VEC;
            ack_vector_o <= 16'h0000;
            ack_msw_o <= 16'h0000;
            ack_src_o <= 5'h00;
            ack_level_o <= 2'h0;
        end else if (launch) begin
            ack_valid_o <= 1'b1;
            ack_kind_o <= next_kind;
            ack_mode_o <= next_mode;
            ack_vector_o <= next_vec;
            ack_msw_o <= next_msw;
            ack_src_o <= next_src;
            ack_level_o <= next_lvl;
        end else if (take) begin
            ack_valid_o <= 1'b0;
        end
    end

    // Non-maskable request from the watchdog; a new event beats the clear.
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            nmi_pend <= 1'b0;
            nmi_busy <= 1'b0;
        end else begin
            nmi_pend <= wdt_overflow_i || (nmi_pend && !(take && ack_kind_o == ira_pkg::KIND_NMI));
            if (take && ack_kind_o == ira_pkg::KIND_NMI) begin
                nmi_busy <= 1'b1;
            end else if (nmi_reti_i) begin
                nmi_busy <= 1'b0;
            end
        end
    end

    // Operand error and software requests; a new event beats the clear.
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            opr_pend <= 1'b0;
            break_pend <= 1'b0;
            break_ctx_pend <= 1'b0;
        end else begin
            opr_pend <= opr_standby_bad_i || opr_watchdog_bad_i || opr_memory_bad_i
                || (opr_pend && !(take && ack_kind_o == ira_pkg::KIND_OPR));
            break_pend <= break_instruction_i || (break_pend && !(take && ack_kind_o == ira_pkg::KIND_SOFT
                && ack_mode_o == ira_pkg::MODE_VEC));
            break_ctx_pend <= break_context_instruction_i || (break_ctx_pend && !(take
                && ack_kind_o == ira_pkg::KIND_SOFT && ack_mode_o == ira_pkg::MODE_CTX));
        end
    end

    // In-service levels: set on a taken non-macro maskable, return clears the top.
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            ispr <= 4'h0;
        end else begin
            ispr <= (ispr & ~(reti_i ? low_bit : 4'h0))
                | ((take && ack_kind_o == ira_pkg::KIND_MASK && ack_mode_o != ira_pkg::MODE_MAC)
                ? (4'h1 << ack_level_o) : 4'h0);
        end
    end

    // Control registers; a hardware request beats a write or the acknowledge clear.
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            for (int i = 0; i < NSRC; i++) begin
                ctl[i] <= `IRA_CTL_RST;
            end
        end else begin
            for (int i = 0; i < NSRC; i++) begin
                if (wr_fire && wr_dec[5] && wr_dec[4:0] == 5'(i) && s_axi_wstrb[0]) begin
                    ctl[i][5:1] <= s_axi_wdata[5:1];
                    ctl[i][`IRA_F_REQ] <= src_req_i[i] || s_axi_wdata[`IRA_F_REQ];
                end else begin
                    ctl[i][`IRA_F_REQ] <= src_req_i[i] || (ctl[i][`IRA_F_REQ] && !(take
                        && ack_kind_o == ira_pkg::KIND_MASK && ack_src_o == 5'(i)));
                end
            end
        end
    end

    // AXI write channel: address and data taken together, one response.
    assign wr_dec = dec_ctl(s_axi_awaddr);
    assign wr_fire = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
    assign s_axi_awready = wr_fire;
    assign s_axi_wready = wr_fire;
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'h0;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            // Status is read-only but mapped; anything else is an error.
            s_axi_bresp <= (wr_dec[5] || s_axi_awaddr == AW'(`IRA_STAT_OFS)) ? 2'h0 : 2'h2;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // AXI read channel: one read at a time, unmapped answers with an error.
    assign rd_dec = dec_ctl(s_axi_araddr);
    assign s_axi_arready = !s_axi_rvalid;
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'h0;
        end else if (s_axi_arvalid && !s_axi_rvalid) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= 2'h0;
            if (rd_dec[5]) begin
                s_axi_rdata <= {26'h0, ctl[rd_dec[4:0]]};
            end else if (s_axi_araddr == AW'(`IRA_STAT_OFS)) begin
                s_axi_rdata <= {26'h0, nmi_busy, nmi_pend, ispr};
            end else begin
                s_axi_rdata <= 32'h0000_0000;
                s_axi_rresp <= 2'h2;
            end
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (srst_i);

    // A free non-maskable request is offered next, ahead of all else.
    chk_nmi_first: assert property (
        launch && nmi_pend && !nmi_busy |=> ack_valid_o && ack_kind_o == ira_pkg::KIND_NMI)
        else $error("non-maskable request not offered first");
    // No second non-maskable offer while its handler runs.
    chk_nmi_hold: assert property (
        nmi_busy && !nmi_reti_i && !ack_valid_o |=> !(ack_valid_o && ack_kind_o == ira_pkg::KIND_NMI))
        else $error("non-maskable offered while busy");
    // A maskable winner is pending and unmasked.
    chk_mask_block: assert property (
        launch && next_kind == ira_pkg::KIND_MASK |-> ctl[next_src][`IRA_F_REQ] && !ctl[next_src][`IRA_F_MASK])
        else $error("masked source offered");
    // Non-macro maskable needs the global enable and a higher level.
    chk_enable_level: assert property (
        launch && next_kind == ira_pkg::KIND_MASK && next_mode != ira_pkg::MODE_MAC
        |-> global_irq_enable_i && {1'b0, next_lvl} < cur_l)
        else $error("maskable offered without enable or level");
    // A software break is offered ahead of maskable work.
    chk_soft_take: assert property (
        launch && break_pend && !nmi_pend && !opr_pend |=> ack_kind_o == ira_pkg::KIND_SOFT
        && ack_vector_o == `IRA_VEC_SOFT)
        else $error("break not offered");
    // Maskable vectors follow the rank table.
    chk_vector_map: assert property (
        ack_valid_o && ack_kind_o == ira_pkg::KIND_MASK |-> ack_vector_o == 16'h0006 + {10'h0, ack_src_o, 1'b0})
        else $error("vector slot does not match rank");
    // Macro service only for sources that offer it.
    chk_macro_ok: assert property (
        ack_valid_o && ack_mode_o == ira_pkg::MODE_MAC |-> MACRO_OK[ack_src_o])
        else $error("macro service on unsupported source");
    // A pulse on rank 0 always leaves its flag set.
    chk_set_wins: assert property (
        src_req_i[0] |=> ctl[0][`IRA_F_REQ])
        else $error("request flag lost");
    // Ties with rank 0 at the same level resolve to rank 0.
    chk_rank_tie: assert property (
        launch && next_kind == ira_pkg::KIND_MASK && next_mode != ira_pkg::MODE_MAC && next_src != 5'h0
        |-> !(ctl[0][`IRA_F_REQ] && !ctl[0][`IRA_F_MASK] && !ctl[0][`IRA_F_MAC] && ctl[0][4:3] == next_lvl))
        else $error("higher rank lost a tie");
    // Any illegal operand leaves an operand error waiting.
    chk_opr_set: assert property (
        opr_standby_bad_i || opr_watchdog_bad_i || opr_memory_bad_i |=> opr_pend)
        else $error("operand error lost");
    // An operand error goes out unless a free non-maskable one waits.
    chk_opr_first: assert property (
        launch && opr_pend && !(nmi_pend && !nmi_busy) |=> ack_kind_o == ira_pkg::KIND_OPR)
        else $error("operand error not offered");
    // A context break is offered with register-bank switching.
    chk_ctx_break: assert property (
        launch && break_ctx_pend && !nmi_pend && !opr_pend && !break_pend
        |=> ack_kind_o == ira_pkg::KIND_SOFT && ack_mode_o == ira_pkg::MODE_CTX)
        else $error("context break not offered");
    // Macro service goes out whatever the enable and the levels.
    chk_macro_free: assert property (
        launch && mac_ok && !nmi_pend && !opr_pend && !break_pend && !break_ctx_pend
        |=> ack_mode_o == ira_pkg::MODE_MAC)
        else $error("macro request held back");
    // With interrupts off only macro service may be maskable.
    chk_mask_off: assert property (
        launch && !global_irq_enable_i && !mac_ok |=> ack_kind_o != ira_pkg::KIND_MASK)
        else $error("maskable offered while disabled");
    // A taken vectored maskable request marks its level in service.
    chk_level_enter: assert property (
        take && ack_kind_o == ira_pkg::KIND_MASK && ack_mode_o != ira_pkg::MODE_MAC
        |=> ispr[$past(ack_level_o)])
        else $error("level not marked in service");
    // Taking the non-maskable offer marks its handler as running.
    chk_busy_set: assert property (
        take && ack_kind_o == ira_pkg::KIND_NMI |=> nmi_busy)
        else $error("non-maskable handler not marked");
endmodule // ira_arbiter
`default_nettype wire

// ---- ira_core_model.sv ----
// Behavioural CPU core that takes the requests offered by the arbiter.
`timescale 1ns/10ps
`default_nettype none
module ira_core_model (
    input wire logic clk_sys_i, // System clock.
    input wire logic srst_i, // Synchronous reset, active high.
    input wire logic slow_i, // High makes the core wait three cycles before taking.
    input wire logic ack_valid_i, // Offer from the arbiter.
    input wire logic [45:0] ack_fields_i, // Kind, mode, vector, word slot, rank, level.
    output logic ack_ready_o, // Acceptance towards the arbiter.
    output logic taken_o, // One-cycle pulse after each take.
    output logic [45:0] taken_fields_o // Fields captured at the take edge.
);
    logic [1:0] wait_cnt; // Cycles spent waiting before accepting.
    // Ready is raised after the chosen delay and held until the take edge, then dropped.
    always_ff @(posedge clk_sys_i) begin
        taken_o <= 1'b0;
        if (srst_i) begin
            ack_ready_o <= 1'b0;
            wait_cnt <= 2'h0;
        end else if (ack_valid_i && ack_ready_o) begin
            ack_ready_o <= 1'b0;
            wait_cnt <= 2'h0;
            taken_o <= 1'b1;
            taken_fields_o <= ack_fields_i;
        end else if (ack_valid_i) begin
            // A slow core lets the offer stand so that holding is exercised.
            if (!slow_i || wait_cnt == 2'h3) begin
                ack_ready_o <= 1'b1;
            end else begin
                wait_cnt <= wait_cnt + 2'h1;
            end
        end
    end
endmodule // ira_core_model
`default_nettype wire

// ---- interrupt_request_arbiter_tb.sv ----
// Self-checking testbench of the interrupt request arbiter.
`timescale 1ns/10ps
`default_nettype none
module interrupt_request_arbiter_tb;
    logic clk_sys_i = 1'b0, srst_i = 1'b1, slow = 1'b0, irq_en = 1'b1; // Clock, reset, core speed, enable.
    logic [7:0] awaddr = 8'h00, araddr = 8'h00; // Bus addresses.
    logic [31:0] wdata = 32'h0, rdata; // Bus data.
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0; // Bus strobes.
    logic awready, wready, bvalid, arready, rvalid, ack_valid, ack_ready, taken; // Design answers.
    logic [1:0] bresp, rresp, ack_level; // Responses and level.
    logic [18:0] src = 19'h0; // Peripheral request pulses.
    logic [7:0] ev = 8'h00; // Break, context break, three operand errors, watchdog, two returns.
    ira_pkg::ira_kind_t ack_kind; // Offered class.
    ira_pkg::ira_mode_t ack_mode; // Offered service mode.
    logic [15:0] ack_vec, ack_msw; // Offered slots.
    logic [4:0] ack_src; // Offered rank.
    logic [45:0] tf; // Fields seen at the take.
    int fail_count = 0, check_count = 0, cyc = 0; // Counters.
    ira_arbiter #(.NSRC(19), .AW(8), .MACRO_OK(19'h7fff7)) u_dut (.clk_sys_i(clk_sys_i), .srst_i(srst_i),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .src_req_i(src), .global_irq_enable_i(irq_en), .break_instruction_i(ev[0]),
        .break_context_instruction_i(ev[1]), .opr_standby_bad_i(ev[2]), .opr_watchdog_bad_i(ev[3]),
        .opr_memory_bad_i(ev[4]), .wdt_overflow_i(ev[5]), .reti_i(ev[6]), .nmi_reti_i(ev[7]),
        .ack_valid_o(ack_valid), .ack_ready_i(ack_ready), .ack_kind_o(ack_kind), .ack_mode_o(ack_mode),
        .ack_vector_o(ack_vec), .ack_msw_o(ack_msw), .ack_src_o(ack_src), .ack_level_o(ack_level));
    ira_core_model u_core (.clk_sys_i(clk_sys_i), .srst_i(srst_i), .slow_i(slow), .ack_valid_i(ack_valid),
        .ack_fields_i({ack_kind, ack_mode, ack_vec, ack_msw, ack_src, ack_level}), .ack_ready_o(ack_ready),
        .taken_o(taken), .taken_fields_o(tf));
    // Clock of 10 ns period.
    initial begin
        forever #5 clk_sys_i = ~clk_sys_i;
    end
    // Prints the counts and the verdict, then stops.
    task results();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // Compares one value with its expectation.
    task check(input logic [63:0] seen, input logic [63:0] exp);
        check_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Cuts a hung run short.
    always @(posedge clk_sys_i) begin
        cyc++;
        if (cyc == 20000) begin
            fail_count++;
            results();
        end
    end
    // Bus write, waiting for the response and comparing its code.
    task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge clk_sys_i);
        awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
        @(posedge clk_sys_i);
        while (awready !== 1'b1) @(posedge clk_sys_i);
        awvalid <= 1'b0; wvalid <= 1'b0;
        while (bvalid !== 1'b1) @(posedge clk_sys_i);
        check(bresp, er);
        bready <= 1'b0;
    endtask
    // Bus read, comparing data and response code.
    task rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        @(posedge clk_sys_i);
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        @(posedge clk_sys_i);
        while (arready !== 1'b1) @(posedge clk_sys_i);
        arvalid <= 1'b0;
        while (rvalid !== 1'b1) @(posedge clk_sys_i);
        check({rresp, rdata}, {er, ed});
        rready <= 1'b0;
    endtask
    // Writes the control register of one rank.
    task cfg(input logic [4:0] n, input logic [5:0] v);
        wr({1'b0, n, 2'b00}, {26'h0, v}, 2'h0);
    endtask
    // One-cycle pulse on request and event inputs.
    task fire(input logic [18:0] s, input logic [7:0] e);
        @(posedge clk_sys_i);
        src <= s; ev <= e;
        @(posedge clk_sys_i);
        src <= 19'h0; ev <= 8'h00;
    endtask
    // Expected fields of a maskable request.
    function logic [45:0] mvec(input logic [4:0] n, input logic [1:0] l, input logic [2:0] m);
        return {4'h8, m, 16'h0006 + {10'h0, n, 1'b0}, 16'hfe06 + {10'h0, n, 1'b0}, n, l};
    endfunction
    // Waits for the core to take an offer and compares it; level counts only for maskable ones.
    task offer(input logic [45:0] e);
        int n;
        n = 0;
        while (taken !== 1'b1 && n < 60) begin
            @(posedge clk_sys_i);
            n++;
        end
        check({taken, tf[45:2], (e[45:42] == 4'h8) ? tf[1:0] : 2'h0}, {1'b1, e});
        @(posedge clk_sys_i);
    endtask
    // Eight cycles in which nothing may be taken.
    task quiet(input logic [63:0] dummy);
        int n;
        n = 0;
        repeat (8) begin
            @(posedge clk_sys_i);
            n += taken;
        end
        check(n, dummy);
    endtask
    // Every rank offers its own vector and control-word slot.
    task t_vectors();
        for (int n = 0; n < 19; n++) begin
            cfg(n[4:0], 6'h00);
            fire(19'h1 << n, 8'h00);
            offer(mvec(n[4:0], 2'h0, 3'h1));
            fire(19'h0, 8'h40);
            cfg(n[4:0], 6'h1a);
        end
    endtask
    // Level beats rank, rank breaks ties, nesting waits for the return.
    task t_ties();
        slow <= 1'b1;
        cfg(5'd4, 6'h08);
        cfg(5'd9, 6'h08);
        cfg(5'd12, 6'h20);
        fire(19'h01210, 8'h00);
        offer(mvec(5'd12, 2'h0, 3'h2));
        quiet(0);
        fire(19'h0, 8'h40);
        offer(mvec(5'd4, 2'h1, 3'h1));
        fire(19'h0, 8'h40);
        offer(mvec(5'd9, 2'h1, 3'h1));
        fire(19'h0, 8'h40);
        slow <= 1'b0;
    endtask
    // Mask flag and global enable hold requests back until released.
    task t_gates();
        cfg(5'd6, 6'h02);
        fire(19'h00040, 8'h00);
        quiet(0);
        cfg(5'd6, 6'h01);
        offer(mvec(5'd6, 2'h0, 3'h1));
        fire(19'h0, 8'h40);
        irq_en <= 1'b0;
        cfg(5'd7, 6'h00);
        fire(19'h00080, 8'h00);
        quiet(0);
        irq_en <= 1'b1;
        offer(mvec(5'd7, 2'h0, 3'h1));
        fire(19'h0, 8'h40);
    endtask
    // Macro service ignores the enable; an incapable source falls back to vectored.
    task t_macro();
        irq_en <= 1'b0;
        cfg(5'd11, 6'h1c);
        fire(19'h00800, 8'h00);
        offer(mvec(5'd11, 2'h3, 3'h4));
        irq_en <= 1'b1;
        cfg(5'd3, 6'h04);
        fire(19'h00008, 8'h00);
        offer(mvec(5'd3, 2'h0, 3'h1));
        fire(19'h0, 8'h40);
    endtask
    // Non-maskable, break and operand-error requests with interrupts disabled.
    task t_special();
        irq_en <= 1'b0;
        fire(19'h0, 8'h21);
        offer({4'h1, 3'h1, 16'h0004, 16'h0000, 5'h00, 2'h0});
        offer({4'h4, 3'h1, 16'h003e, 16'h0000, 5'h00, 2'h0});
        fire(19'h0, 8'h20);
        quiet(0);
        rd(8'h80, 32'h00000030, 2'h0);
        fire(19'h0, 8'h80);
        offer({4'h1, 3'h1, 16'h0004, 16'h0000, 5'h00, 2'h0});
        fire(19'h0, 8'h80);
        fire(19'h0, 8'h02);
        offer({4'h4, 3'h2, 16'h0000, 16'h0000, 5'h00, 2'h0});
        for (int i = 2; i < 5; i++) begin
            fire(19'h0, 8'h01 << i);
            offer({4'h2, 3'h1, 16'h003c, 16'h0000, 5'h00, 2'h0});
        end
        irq_en <= 1'b1;
    endtask
    // Main sequence: reset for 12 cycles, then the scenarios.
    initial begin
        repeat (12) @(posedge clk_sys_i);
        srst_i <= 1'b0;
        @(posedge clk_sys_i);
        check(ack_valid, 1'b0);
        rd(8'h14, 32'h0000001a, 2'h0);
        rd(8'h84, 32'h0, 2'h2);
        wr(8'h84, 32'h0, 2'h2);
        t_vectors();
        t_ties();
        t_gates();
        t_macro();
        t_special();
        results();
    end
endmodule // interrupt_request_arbiter_tb
`default_nettype wire
